/* File: asi_irq_regs.sv */
// Purpose: Interrupt enable, clear and masked status for an audio serial
//          port, plus the receive end-of-frame word counter.
// Assumes: Raw event pulses come from logic on clk_sys_i.
// Notes:   Flags, enables and masked status share one bit layout.
`timescale 1ns/10ps
`default_nettype none
module asi_irq_regs
   import asi_pkg::*;
(
   input  wire logic                   clk_sys_i,
   input  wire logic                   nrst_i,
   input  wire asi_apb_req_type        apb_req_i,
   output var  asi_apb_rsp_type        apb_rsp_o,
   input  wire logic [ASI_NUM_SRC-1:0] event_pulse_i,
   input  wire logic                   rx_word_i,
   output logic                        irq_o
);
   logic [ASI_NUM_SRC-1:0] raw_flag;
   logic [ASI_NUM_SRC-1:0] next_raw_flag;
   logic [ASI_NUM_SRC-1:0] irq_enable;
   logic [ASI_NUM_SRC-1:0] next_irq_enable;
   logic [31:0]            rx_frame_length;
   logic [31:0]            next_rx_frame_length;
   logic [31:0]            rx_count;
   logic [31:0]            next_rx_count;
   asi_apb_rsp_type        next_rsp;
   logic                   next_irq;
   logic [ASI_NUM_SRC-1:0] masked;
   logic [ASI_NUM_SRC-1:0] next_masked;
   logic [ASI_NUM_SRC-1:0] set_vec;
   logic [ASI_NUM_SRC-1:0] clr_vec;
   logic                   wr_en;
   logic                   rd_en;
   logic                   rx_eof;

   // The slave answers in the first access cycle, so pready is set by the
   // setup cycle and the master's access phase lasts exactly one edge.
   always_comb begin
      wr_en = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
      rd_en = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
      next_rx_count = rx_count;
      rx_eof = 1'b0;
      if (rx_word_i) begin
         if (rx_count + ASI_CNT_ONE >= rx_frame_length) begin
            rx_eof = 1'b1;
            next_rx_count = ASI_CNT_RESET;
         end else begin
            next_rx_count = rx_count + ASI_CNT_ONE;
         end
      end
      set_vec = event_pulse_i;
      set_vec[ASI_BIT_RX_EOF] = event_pulse_i[ASI_BIT_RX_EOF] | rx_eof;
      clr_vec = ASI_ZERO16;
      if (wr_en && apb_req_i.paddr == ASI_OFF_CLEAR) begin
         clr_vec = apb_req_i.pwdata[ASI_NUM_SRC-1:0];
      end
      // A flag raised in the same cycle as its clear stays set.
      next_raw_flag = (raw_flag & ~clr_vec) | set_vec;
      next_irq_enable = irq_enable;
      next_rx_frame_length = rx_frame_length;
      if (wr_en && apb_req_i.paddr == ASI_OFF_ENABLE) begin
         next_irq_enable = apb_req_i.pwdata[ASI_NUM_SRC-1:0];
      end
      if (wr_en && apb_req_i.paddr == ASI_OFF_RXLEN) begin
         next_rx_frame_length = apb_req_i.pwdata;
      end
      next_masked = next_raw_flag & next_irq_enable;
      next_irq = |next_masked;
      next_rsp = '0;
      next_rsp.pready = apb_req_i.psel & ~apb_req_i.penable;
      if (rd_en) begin
         unique case (apb_req_i.paddr)
            ASI_OFF_RAW:    next_rsp.prdata = {ASI_ZERO16, raw_flag};
            ASI_OFF_MASKED: next_rsp.prdata = {ASI_ZERO16, masked};
            ASI_OFF_ENABLE: next_rsp.prdata = {ASI_ZERO16, irq_enable};
            ASI_OFF_CLEAR:  next_rsp.prdata = ASI_ZERO32;
            ASI_OFF_RXLEN:  next_rsp.prdata = rx_frame_length;
            ASI_OFF_RXCNT:  next_rsp.prdata = rx_count;
            default:        next_rsp.pslverr = 1'b1;
         endcase
      end else if (apb_req_i.psel && !apb_req_i.penable) begin
         unique case (apb_req_i.paddr)
            ASI_OFF_ENABLE, ASI_OFF_CLEAR, ASI_OFF_RXLEN:
               next_rsp.pslverr = 1'b0;
            default:
               next_rsp.pslverr = 1'b1; // Read-only or unmapped target.
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         raw_flag        <= ASI_FLAG_RESET;
         irq_enable      <= ASI_ENA_RESET;
         rx_frame_length <= ASI_LEN_RESET;
         rx_count        <= ASI_CNT_RESET;
         masked          <= ASI_FLAG_RESET;
         irq_o           <= 1'b0;
         apb_rsp_o       <= '0;
      end else begin
         raw_flag        <= next_raw_flag;
         irq_enable      <= next_irq_enable;
         rx_frame_length <= next_rx_frame_length;
         rx_count        <= next_rx_count;
         masked          <= next_masked;
         irq_o           <= next_irq;
         apb_rsp_o       <= next_rsp;
      end
   end

   logic wr_clear;
   logic wr_masked;
   assign wr_clear  = wr_en && apb_req_i.paddr == ASI_OFF_CLEAR;
   assign wr_masked = wr_en && apb_req_i.paddr == ASI_OFF_MASKED;

   property p_masked_and;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      masked == (raw_flag & irq_enable);
   endproperty
   a_masked_and: assert property (p_masked_and)
      else $error("Masked status differs from flag and enable.");

   property p_masked_ro;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      wr_masked && !(|event_pulse_i) && !rx_word_i |=> $stable(masked);
   endproperty
   a_masked_ro: assert property (p_masked_ro)
      else $error("Write changed the masked status.");

   property p_enable_wr;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      wr_en && apb_req_i.paddr == ASI_OFF_ENABLE
      |=> irq_enable == $past(apb_req_i.pwdata[ASI_NUM_SRC-1:0]);
   endproperty
   a_enable_wr: assert property (p_enable_wr)
      else $error("Enable register did not take the written value.");

   property p_clear_ones;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      wr_clear && !(|event_pulse_i) && !rx_word_i
      |=> (raw_flag & $past(apb_req_i.pwdata[ASI_NUM_SRC-1:0])) == ASI_ZERO16;
   endproperty
   a_clear_ones: assert property (p_clear_ones)
      else $error("Clear write left a flag set.");

   property p_clear_read_zero;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rd_en && apb_req_i.paddr == ASI_OFF_CLEAR |=> apb_rsp_o.prdata == ASI_ZERO32;
   endproperty
   a_clear_read_zero: assert property (p_clear_read_zero)
      else $error("Clear register read returned data.");

   property p_rx_eof;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rx_word_i && (rx_count + ASI_CNT_ONE >= rx_frame_length)
      |=> raw_flag[ASI_BIT_RX_EOF] ##0 rx_count == ASI_CNT_RESET;
   endproperty
   a_rx_eof: assert property (p_rx_eof)
      else $error("End-of-frame not raised at programmed length.");

   sequence s_pending;
      |masked;
   endsequence
   property p_irq_level;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      irq_o == (|masked);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("Interrupt level disagrees with masked status.");

   property p_irq_drop;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_pending ##1 !(|masked) |-> !irq_o;
   endproperty
   a_irq_drop: assert property (p_irq_drop)
      else $error("Interrupt held after all status cleared.");

   // Bus setup phase, so that the answer timing can be stated step by step.
   sequence s_setup;
      apb_req_i.psel && !apb_req_i.penable;
   endsequence

   property p_ready_pulse;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_setup |=> apb_rsp_o.pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("No ready in the access cycle.");

   property p_ready_once;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      apb_rsp_o.pready |=> !apb_rsp_o.pready;
   endproperty
   a_ready_once: assert property (p_ready_once)
      else $error("Ready stood longer than one cycle.");

   property p_masked_read;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rd_en && apb_req_i.paddr == ASI_OFF_MASKED
      |=> apb_rsp_o.prdata == {ASI_ZERO16, $past(masked)};
   endproperty
   a_masked_read: assert property (p_masked_read)
      else $error("Masked status read returned wrong data.");

   property p_masked_wr_err;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      s_setup ##0 apb_req_i.pwrite && apb_req_i.paddr == ASI_OFF_MASKED
      |=> apb_rsp_o.pslverr;
   endproperty
   a_masked_wr_err: assert property (p_masked_wr_err)
      else $error("Write to masked status was not refused.");

   property p_enable_read;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rd_en && apb_req_i.paddr == ASI_OFF_ENABLE
      |=> apb_rsp_o.prdata == {ASI_ZERO16, $past(irq_enable)};
   endproperty
   a_enable_read: assert property (p_enable_read)
      else $error("Enable read returned wrong data.");

   property p_enable_hold;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      !(wr_en && apb_req_i.paddr == ASI_OFF_ENABLE) |=> $stable(irq_enable);
   endproperty
   a_enable_hold: assert property (p_enable_hold)
      else $error("Enable changed without a write.");

   // The set must win so that an event arriving during service is not lost.
   property p_set_wins;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      wr_clear && (|event_pulse_i)
      |=> (raw_flag & $past(event_pulse_i)) == $past(event_pulse_i);
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("Clear removed a flag raised in the same cycle.");

   property p_clear_zero_keeps;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      wr_clear && !(|event_pulse_i) && !rx_word_i
      |=> (raw_flag & ~$past(apb_req_i.pwdata[ASI_NUM_SRC-1:0]))
          == ($past(raw_flag) & ~$past(apb_req_i.pwdata[ASI_NUM_SRC-1:0]));
   endproperty
   a_clear_zero_keeps: assert property (p_clear_zero_keeps)
      else $error("Writing zero to clear changed a flag.");

   property p_clear_no_state;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      !wr_clear && !(|event_pulse_i) && !rx_word_i
      |=> raw_flag == $past(raw_flag);
   endproperty
   a_clear_no_state: assert property (p_clear_no_state)
      else $error("A flag changed with no event and no clear.");

   property p_count_step;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rx_word_i && (rx_count + ASI_CNT_ONE < rx_frame_length)
      |=> rx_count == $past(rx_count) + ASI_CNT_ONE;
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("Word counter did not advance by one.");

   property p_count_hold;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      !rx_word_i |=> $stable(rx_count);
   endproperty
   a_count_hold: assert property (p_count_hold)
      else $error("Word counter moved without a word.");

   property p_no_early_eof;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rx_word_i && (rx_count + ASI_CNT_ONE < rx_frame_length)
      && !event_pulse_i[ASI_BIT_RX_EOF] && !raw_flag[ASI_BIT_RX_EOF]
      |=> !raw_flag[ASI_BIT_RX_EOF];
   endproperty
   a_no_early_eof: assert property (p_no_early_eof)
      else $error("End-of-frame raised before the programmed length.");

   property p_len_write;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      wr_en && apb_req_i.paddr == ASI_OFF_RXLEN
      |=> rx_frame_length == $past(apb_req_i.pwdata);
   endproperty
   a_len_write: assert property (p_len_write)
      else $error("Frame length did not take the written value.");

   property p_count_read;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      rd_en && apb_req_i.paddr == ASI_OFF_RXCNT
      |=> apb_rsp_o.prdata == $past(rx_count);
   endproperty
   a_count_read: assert property (p_count_read)
      else $error("Word count read returned wrong data.");

   property p_irq_set;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      (|(event_pulse_i & irq_enable)) && !wr_en
      |=> irq_o;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("Enabled event did not raise the interrupt.");

   property p_irq_quiet;
      @(posedge clk_sys_i) disable iff (!nrst_i)
      !(|(raw_flag & irq_enable)) && !(|event_pulse_i) && !rx_word_i
      && !wr_en
      |=> !irq_o;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("Interrupt raised with nothing pending.");
endmodule : asi_irq_regs
`default_nettype wire

/* File: asi_pkg.sv */
// Purpose: Constants and types for the audio serial interrupt register block.
// Assumes: APB slave with 32-bit data, word-aligned registers.
// Notes:   Sixteen event sources share one bit layout in the flag, masked, enable and clear registers.
package asi_pkg;
   localparam int          ASI_NUM_SRC    = 16;
   localparam int          ASI_ADDR_W     = 8;
   localparam logic [7:0]  ASI_OFF_RAW    = 8'h0c;
   localparam logic [7:0]  ASI_OFF_MASKED = 8'h10;
   localparam logic [7:0]  ASI_OFF_ENABLE = 8'h14;
   localparam logic [7:0]  ASI_OFF_CLEAR  = 8'h18;
   localparam logic [7:0]  ASI_OFF_RXLEN  = 8'h24;
   localparam logic [7:0]  ASI_OFF_RXCNT  = 8'h38;
   localparam logic [15:0] ASI_ENA_RESET  = 16'h0000;
   localparam logic [15:0] ASI_FLAG_RESET = 16'h0000;
   localparam logic [31:0] ASI_LEN_RESET  = 32'h0000_0080;
   localparam logic [31:0] ASI_CNT_RESET  = 32'h0000_0000;
   localparam logic [31:0] ASI_CNT_ONE    = 32'h0000_0001;
   localparam logic [15:0] ASI_ZERO16     = 16'h0000;
   localparam logic [31:0] ASI_ZERO32     = 32'h0000_0000;
   // Bit of the receive end-of-frame source within every event vector.
   localparam int          ASI_BIT_RX_EOF = 9;

   typedef struct packed {
      logic                  psel;
      logic                  penable;
      logic                  pwrite;
      logic [ASI_ADDR_W-1:0] paddr;
      logic [31:0]           pwdata;
   } asi_apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } asi_apb_rsp_type;
endpackage : asi_pkg

/* File: tb_top.sv */
// Purpose: Self-checking bench for the audio serial interrupt registers.
// Assumes: APB slave answers with pready; flags show one edge after pulse.
// Notes:   Register reads double as checks; all waits are bounded.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import asi_pkg::*;
   logic                   clk_sys_i;
   logic                   nrst_i;
   logic                   rx_word;
   logic                   irq;
   logic [ASI_NUM_SRC-1:0] ev;
   asi_apb_req_type        req;
   asi_apb_rsp_type        rsp;
   logic [31:0]            q;
   logic                   err;
   int                     num_errors;
   int                     n_checks;

   asi_irq_regs asi_irq_regs_inst (
      .clk_sys_i     (clk_sys_i),
      .nrst_i        (nrst_i),
      .apb_req_i     (req),
      .apb_rsp_o     (rsp),
      .event_pulse_i (ev),
      .rx_word_i     (rx_word),
      .irq_o         (irq)
   );

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   task summarize;
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : check

   // An idle edge first, so a new setup never lands on the release edge.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk_sys_i);
      req <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk_sys_i);
      req.penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk_sys_i);
         i++;
      end while (rsp.pready !== 1'b1 && i < 20);
      if (i >= 20) begin
         num_errors++;
         summarize();
      end
      q = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      check(nm, e, q);
   endtask : rd

   task pulse(input logic [15:0] v, input logic w);
      @(posedge clk_sys_i);
      ev <= v;
      rx_word <= w;
      @(posedge clk_sys_i);
      ev <= 16'h0000;
      rx_word <= 1'b0;
   endtask : pulse

   initial begin
      req = '0;
      ev = 16'h0000;
      rx_word = 1'b0;
      nrst_i = 1'b0;
      num_errors = 0;
      n_checks = 0;
      repeat (6) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd(ASI_OFF_MASKED, 32'h0000_0000, "masked_reset");
      rd(ASI_OFF_ENABLE, 32'h0000_0000, "enable_reset");
      apb(1'b1, ASI_OFF_ENABLE, 32'hffff_00ff);
      rd(ASI_OFF_ENABLE, 32'h0000_00ff, "enable_rw");
      pulse(16'hffff, 1'b0);
      rd(ASI_OFF_RAW, 32'h0000_ffff, "raw_all");
      rd(ASI_OFF_MASKED, 32'h0000_00ff, "masked_and");
      check("irq_high", 32'h1, {31'h0, irq});
      apb(1'b1, ASI_OFF_MASKED, 32'h0000_0000);
      check("masked_wr_err", 32'h1, {31'h0, err});
      rd(ASI_OFF_MASKED, 32'h0000_00ff, "masked_ro");
      rd(ASI_OFF_CLEAR, 32'h0000_0000, "clear_read");
      apb(1'b1, ASI_OFF_CLEAR, 32'h0000_000f);
      rd(ASI_OFF_MASKED, 32'h0000_00f0, "clear_ones");
      apb(1'b1, ASI_OFF_ENABLE, 32'h0000_0000);
      rd(ASI_OFF_MASKED, 32'h0000_0000, "masked_off");
      check("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, ASI_OFF_ENABLE, 32'h0000_ffff);
      rd(ASI_OFF_MASKED, 32'h0000_fff0, "enable_back");
      apb(1'b1, ASI_OFF_CLEAR, 32'h0000_ffff);
      rd(ASI_OFF_MASKED, 32'h0000_0000, "clear_all");
      check("irq_low", 32'h0, {31'h0, irq});
      pulse(16'h0001, 1'b0);
      rd(ASI_OFF_MASKED, 32'h0000_0001, "clear_no_state");
      rd(8'h40, 32'h0000_0000, "unmapped_data");
      check("unmapped_err", 32'h1, {31'h0, err});
      // Receive end-of-frame after exactly three words.
      apb(1'b1, ASI_OFF_CLEAR, 32'h0000_ffff);
      apb(1'b1, ASI_OFF_ENABLE, 32'h0000_0200);
      apb(1'b1, ASI_OFF_RXLEN, 32'h0000_0003);
      pulse(16'h0000, 1'b1);
      pulse(16'h0000, 1'b1);
      rd(ASI_OFF_MASKED, 32'h0000_0000, "eof_early");
      rd(ASI_OFF_RXCNT, 32'h0000_0002, "word_count");
      pulse(16'h0000, 1'b1);
      rd(ASI_OFF_MASKED, 32'h0000_0200, "eof_reached");
      check("irq_eof", 32'h1, {31'h0, irq});
      summarize();
   end
endmodule : tb_top
`default_nettype wire
